// ===== logic/uphy_consts.svh
// Contract
// - Decode speed select: HS, FS, LS, LS-FS-edges
// - Termination select 0 HS, 1 FS
// - Link presents a byte while valid high
// - Ready acknowledges byte taken, next accepted
// - Link may ignore ready when not valid
// - Active-low suspend input enters low power
// - Suspend: host drops pull-up; device keeps pull-down
// - Clocks stop while suspended
// - Valid rise starts SYNC
// - Valid fall starts end-of-packet
// - Link holds mode/select inputs at valid edges
// - Reset returns all state machines to idle
// - Link waits five edges after reset
// - Reset asserts anytime, releases synchronously; the link also raises it only on a clock edge, and the PHY acts on it at one
// - All interface signals synchronous to output clock
`ifndef UPHY_CONSTS_SVH
`define UPHY_CONSTS_SVH
`define UPHY_XS_HS 2'h0
`define UPHY_XS_FS 2'h1
`define UPHY_XS_LS 2'h2
`define UPHY_XS_LSFS 2'h3
`define UPHY_TERM_HS 1'h0
`define UPHY_TERM_FS 1'h1
`define UPHY_RST_WAIT 3'h5
`define UPHY_SYNC_LEN 3'h4
`define UPHY_EOP_LEN 3'h3
`define UPHY_CLK_HZ 25000000
`define UPHY_PHY_CLK_HZ 60000000
`endif

// ===== logic/uphy_pkg.sv
package uphy_pkg;
   typedef enum logic [1:0] {
      UPHY_SPD_HS = 2'h0,
      UPHY_SPD_FS = 2'h1,
      UPHY_SPD_LS = 2'h2,
      UPHY_SPD_LSFS = 2'h3
   } uphy_speed_t;
   typedef enum logic [1:0] {
      UPHY_TX_IDLE = 2'h0,
      UPHY_TX_SYNC = 2'h1,
      UPHY_TX_DATA = 2'h2,
      UPHY_TX_EOP = 2'h3
   } uphy_tx_state_t;
endpackage

// ===== logic/uphy_if.sv
`timescale 1ns/100ps
`default_nettype none
interface uphy_if;
   logic [1:0] transceiver_speed_select;
   logic termination_select;
   logic suspend_active_low;
   logic [1:0] operational_mode_select;
   logic tx_valid;
   logic tx_ready;
   logic [7:0] tx_data;
   logic phy_reset;
   logic phy_clock_run;
   modport phy (
      input transceiver_speed_select, termination_select, suspend_active_low,
      input operational_mode_select, tx_valid, tx_data, phy_reset,
      output tx_ready, phy_clock_run
   );
   modport link (
      output transceiver_speed_select, termination_select, suspend_active_low,
      output operational_mode_select, tx_valid, tx_data, phy_reset,
      input tx_ready, phy_clock_run
   );
endinterface
`default_nettype wire

// ===== logic/uphy_phy.sv
`timescale 1ns/100ps
`default_nettype none
`include "uphy_consts.svh"
module uphy_phy
   import uphy_pkg::*;
#(
   parameter int DATA_W = 8
) (
   // Clock and local reset
   input wire logic clk,
   input wire logic rst,
   // Link side
   uphy_if.phy lnk,
   // Line-side controls
   input wire logic host_mode,
   output logic hs_termination_on,
   output logic fs_termination_on,
   output logic line_pullup_resistor,
   output logic line_pulldown_resistor,
   output logic [1:0] line_speed,
   output logic fs_edge_rate,
   output logic low_power,
   // Serialiser side
   output logic line_sync,
   output logic line_eop,
   output logic line_valid,
   output logic [DATA_W-1:0] line_data,
   input wire logic line_ready
);
   // Sequencer state and its cycle counter
   uphy_tx_state_t state;
   logic [2:0] cnt;
   logic ending;
   logic srst;
   logic susp;
   // Two-entry buffer so a stalled serialiser loses no byte
   logic [DATA_W-1:0] buf_mem [0:1];
   logic [1:0] buf_cnt;
   logic [1:0] next_cnt;
   logic wp, rp;
   logic take, load;

   // Either reset source clears every state machine
   assign srst = rst | lnk.phy_reset;
   assign susp = ~lnk.suspend_active_low;
   // Head moves to the output flop whenever that flop is free or being emptied;
   // a word written at this edge is not readable until the next one
   assign load = (buf_cnt != 2'h0) && (!line_valid || line_ready);
   assign take = lnk.tx_valid & lnk.tx_ready;

   // Speed and termination decode, registered to the clock
   always_ff @(posedge clk) begin
      if (srst) begin
         // Full speed is the safe setting until the link chooses
         line_speed <= `UPHY_XS_FS;
         fs_edge_rate <= 1'b1;
         hs_termination_on <= 1'b0;
         fs_termination_on <= 1'b1;
      end else begin
         unique case (lnk.transceiver_speed_select)
            `UPHY_XS_HS: begin
               line_speed <= UPHY_SPD_HS;
               fs_edge_rate <= 1'b0;
            end
            `UPHY_XS_FS: begin
               line_speed <= UPHY_SPD_FS;
               fs_edge_rate <= 1'b1;
            end
            `UPHY_XS_LS: begin
               line_speed <= UPHY_SPD_LS;
               fs_edge_rate <= 1'b0;
            end
            `UPHY_XS_LSFS: begin
               line_speed <= UPHY_SPD_LS; // LS data at FS edges
               fs_edge_rate <= 1'b1;
            end
         endcase
         hs_termination_on <= (lnk.termination_select == `UPHY_TERM_HS);
         fs_termination_on <= (lnk.termination_select == `UPHY_TERM_FS);
      end
   end

   // Suspend: low power, clock gated off, pull-up/pull-down policy
   // A packet in flight is not cut by suspend; only ready drops
   always_ff @(posedge clk) begin
      if (srst) begin
         low_power <= 1'b0;
         lnk.phy_clock_run <= 1'b1;
         line_pullup_resistor <= 1'b0;
         line_pulldown_resistor <= 1'b0;
      end else begin
         low_power <= susp;
         lnk.phy_clock_run <= ~susp;
         // Host drops its pull-up in suspend; a device's pull-down follows termination
         line_pullup_resistor <= host_mode & ~susp & lnk.termination_select;
         line_pulldown_resistor <= ~host_mode & lnk.termination_select;
      end
   end

   // Transmit sequencer: SYNC when valid rises, EOP once valid falls and the buffer drains
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= UPHY_TX_IDLE;
         cnt <= 3'h0;
         ending <= 1'b0;
      end else begin
         unique case (state)
            UPHY_TX_IDLE: begin
               // Start on the level: valid is only high here after it rose, and a
               // packet raised during the previous EOP is still started
               if (lnk.tx_valid && !susp) begin
                  state <= UPHY_TX_SYNC;
                  cnt <= `UPHY_SYNC_LEN;
               end
            end
            UPHY_TX_SYNC: begin
               if (cnt == 3'h1) begin
                  state <= UPHY_TX_DATA;
               end
               cnt <= cnt - 3'h1;
            end
            UPHY_TX_DATA: begin
               // Once valid falls the packet is closed, even if valid returns early
               if (!lnk.tx_valid) begin
                  ending <= 1'b1;
               end
               // EOP only after the last byte has left the output flop
               if ((ending || !lnk.tx_valid) && buf_cnt == 2'h0 && !line_valid) begin
                  state <= UPHY_TX_EOP;
                  cnt <= `UPHY_EOP_LEN;
                  ending <= 1'b0;
               end
            end
            UPHY_TX_EOP: begin
               if (cnt == 3'h1) begin
                  state <= UPHY_TX_IDLE;
               end
               cnt <= cnt - 3'h1;
            end
         endcase
      end
   end

   // Line markers straight from flops
   always_ff @(posedge clk) begin
      if (srst) begin
         line_sync <= 1'b0;
         line_eop <= 1'b0;
      end else begin
         line_sync <= (state == UPHY_TX_SYNC);
         line_eop <= (state == UPHY_TX_EOP);
      end
   end

   // Fill level after this edge: one word in from the link, one out to the output flop
   always_comb begin
      next_cnt = buf_cnt;
      if (take && !load) begin
         next_cnt = buf_cnt + 2'h1;
      end else if (!take && load) begin
         next_cnt = buf_cnt - 2'h1;
      end
   end

   // Ready is a flop, so it looks at the fill level after this edge; a full
   // buffer, a closing packet or suspend holds it low
   always_ff @(posedge clk) begin
      if (srst) begin
         lnk.tx_ready <= 1'b0;
      end else begin
         lnk.tx_ready <= ((state == UPHY_TX_DATA && !ending)
                          || (state == UPHY_TX_SYNC && cnt == 3'h1))
                         && lnk.tx_valid && !susp && (next_cnt != 2'h2);
      end
   end

   // Buffer write and read pointers
   // Memory is not reset; only words counted in buf_cnt are ever read
   always_ff @(posedge clk) begin
      if (srst) begin
         buf_cnt <= 2'h0;
         wp <= 1'b0;
         rp <= 1'b0;
      end else begin
         buf_cnt <= next_cnt;
         if (take) begin
            buf_mem[wp] <= lnk.tx_data;
            wp <= ~wp;
         end
         if (load) begin
            rp <= ~rp;
         end
      end
   end

   // Output stage presents the head of the buffer from a flop
   always_ff @(posedge clk) begin
      if (srst) begin
         line_valid <= 1'b0;
         line_data <= '0;
      end else if (load) begin
         line_valid <= 1'b1;
         line_data <= buf_mem[rp];
      end else if (line_ready) begin
         line_valid <= 1'b0; // Word left and nothing waits behind it
      end
   end
endmodule
`default_nettype wire

// ===== logic/uphy_link.sv
`timescale 1ns/100ps
`default_nettype none
`include "uphy_consts.svh"
module uphy_link
   import uphy_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // User side
   input wire logic [1:0] cfg_speed,
   input wire logic cfg_term,
   input wire logic [1:0] cfg_operational_mode_select,
   input wire logic cfg_suspend,
   input wire logic cfg_phy_reset,
   input wire logic usr_valid,
   input wire logic [7:0] usr_data,
   input wire logic usr_last,
   output logic usr_ready,
   // PHY side
   uphy_if.link phy
);
   logic [2:0] wait_cnt;
   logic sending;
   logic valid_q;
   logic usr_last_q;

   // Count five edges after PHY reset release before any transmit
   always_ff @(posedge clk) begin
      if (rst || cfg_phy_reset) begin
         wait_cnt <= 3'h0;
      end else if (wait_cnt != `UPHY_RST_WAIT) begin
         wait_cnt <= wait_cnt + 3'h1;
      end
   end

   // Reset raised and released only on this clock
   always_ff @(posedge clk) begin
      if (rst) begin
         phy.phy_reset <= 1'b1;
         phy.suspend_active_low <= 1'b1;
      end else begin
         phy.phy_reset <= cfg_phy_reset;
         phy.suspend_active_low <= ~cfg_suspend;
      end
   end

   // Controls change only while no packet is in flight, nor at the edge that starts one
   always_ff @(posedge clk) begin
      if (rst) begin
         phy.transceiver_speed_select <= `UPHY_XS_FS;
         phy.termination_select <= `UPHY_TERM_FS;
         phy.operational_mode_select <= 2'h0;
      end else if (!sending && !valid_q && !usr_ready) begin
         phy.transceiver_speed_select <= cfg_speed;
         phy.termination_select <= cfg_term;
         phy.operational_mode_select <= cfg_operational_mode_select;
      end
   end

   // Packet driver: valid held with a byte present until last taken
   always_ff @(posedge clk) begin
      if (rst || phy.phy_reset) begin
         sending <= 1'b0;
         valid_q <= 1'b0;
         phy.tx_valid <= 1'b0;
         phy.tx_data <= 8'h00;
      end else begin
         valid_q <= phy.tx_valid;
         if (!sending) begin
            if (usr_valid && wait_cnt == `UPHY_RST_WAIT && phy.suspend_active_low) begin
               sending <= 1'b1;
               phy.tx_valid <= 1'b1;
               phy.tx_data <= usr_data;
            end
         end else if (phy.tx_valid && phy.tx_ready) begin
            if (usr_last_q) begin
               sending <= 1'b0;
               phy.tx_valid <= 1'b0;
            end else begin
               phy.tx_data <= usr_data;
            end
         end
      end
   end

   // Remember whether held byte is last
   always_ff @(posedge clk) begin
      if (rst) begin
         usr_last_q <= 1'b0;
      end else if (usr_ready && usr_valid) begin
         usr_last_q <= usr_last;
      end
   end

   // User byte taken at packet start and whenever a held byte other than the last moves to the PHY
   always_comb begin
      usr_ready = (!sending && usr_valid && wait_cnt == `UPHY_RST_WAIT
                   && phy.suspend_active_low && !phy.phy_reset && !rst)
                  || (sending && phy.tx_valid && phy.tx_ready && !usr_last_q
                      && !phy.phy_reset && !rst);
   end
endmodule
`default_nettype wire

// ===== tb/uphy_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module uphy_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link to PHY signals
   input wire logic [1:0] transceiver_speed_select,
   input wire logic termination_select,
   input wire logic suspend_active_low,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic phy_reset,
   input wire logic phy_clock_run
);
   // Single domain, so clock and disable are stated once
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Sync occupies the first cycles, so no byte is taken then
   a_sync_blocks_ready: assert property ($rose(tx_valid) |=> !tx_ready [*3])
      else $error("ready raised during sync");
   a_ready_after_sync: assert property ($rose(tx_valid) |-> ##[3:8] tx_ready)
      else $error("ready late after valid");
   a_byte_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("byte dropped before taken");
   a_ctrl_steady: assert property ($changed(tx_valid) |->
      $stable(termination_select) && $stable(transceiver_speed_select))
      else $error("control changed at valid edge");
   a_reset_gap: assert property ($fell(phy_reset) |-> !tx_valid [*5])
      else $error("valid too soon after reset");
   a_reset_clears: assert property (phy_reset |=> !tx_ready)
      else $error("ready during reset");
   a_suspend_quiet: assert property (!suspend_active_low [*2] |-> !tx_ready)
      else $error("ready while suspended");
   a_clock_stops: assert property (!suspend_active_low [*2] |-> !phy_clock_run)
      else $error("clock runs in suspend");
   a_clock_runs: assert property (suspend_active_low [*2] |-> phy_clock_run)
      else $error("clock stopped while awake");

   // Main scenarios reached
   c_packet: cover property ($rose(tx_valid));
   c_taken: cover property (tx_valid && tx_ready);
   c_suspend: cover property ($fell(suspend_active_low));
endmodule
`default_nettype wire

// ===== tb/test_utmi_phy_control_pins.sv
`timescale 1ns/100ps
`default_nettype none
module test_utmi_phy_control_pins;
   import uphy_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] cfg_speed = 2'h1;
   logic cfg_term = 1'h1;
   logic cfg_suspend = 1'h0;
   logic cfg_phy_reset = 1'h0;
   logic usr_valid = 1'h0;
   logic [7:0] usr_data = 8'h00;
   logic usr_last = 1'h0;
   logic usr_ready;
   logic line_ready = 1'h1;
   logic stall_en = 1'h0;
   logic hs_on, fs_on, pu_line, low_power, line_sync, line_eop, line_valid, fs_edge;
   logic host_mode = 1'h1;
   logic pd_line;
   logic sync_q = 1'h0;
   logic eop_q = 1'h0;
   logic [1:0] line_speed;
   logic [7:0] line_data;
   int err_total = 0;
   int n_tests = 0;
   integer seed = 32'hF3FC5D23;
   int n_sync = 0;
   int n_eop = 0;
   logic [7:0] sent[$];
   logic [7:0] got[$];

   uphy_if i_uphy_if ();
   uphy_link i_uphy_link (.clk(clk), .rst(rst), .cfg_speed(cfg_speed), .cfg_term(cfg_term),
      .cfg_operational_mode_select(2'h0), .cfg_suspend(cfg_suspend), .cfg_phy_reset(cfg_phy_reset),
      .usr_valid(usr_valid), .usr_data(usr_data), .usr_last(usr_last),
      .usr_ready(usr_ready), .phy(i_uphy_if.link));
   uphy_phy i_uphy_phy (.clk(clk), .rst(rst), .lnk(i_uphy_if.phy), .host_mode(host_mode),
      .hs_termination_on(hs_on), .fs_termination_on(fs_on), .line_pullup_resistor(pu_line),
      .line_pulldown_resistor(pd_line), .line_speed(line_speed), .fs_edge_rate(fs_edge),
      .low_power(low_power), .line_sync(line_sync), .line_eop(line_eop),
      .line_valid(line_valid), .line_data(line_data), .line_ready(line_ready));
   uphy_assertions i_uphy_assertions (.clk(clk), .rst(rst),
      .transceiver_speed_select(i_uphy_if.transceiver_speed_select),
      .termination_select(i_uphy_if.termination_select),
      .suspend_active_low(i_uphy_if.suspend_active_low), .tx_valid(i_uphy_if.tx_valid),
      .tx_ready(i_uphy_if.tx_ready), .tx_data(i_uphy_if.tx_data),
      .phy_reset(i_uphy_if.phy_reset), .phy_clock_run(i_uphy_if.phy_clock_run));

   always #20 clk = ~clk;

   // Serialiser stalls at random so the buffer has to hold words
   always @(posedge clk) #1 line_ready = stall_en ? 1'($random(seed)) : 1'b1;

   // Collect line-side bytes and count framing pulses by their rising edges
   always @(posedge clk) begin
      if (line_valid && line_ready) got.push_back(line_data);
      if (line_sync && !sync_q) n_sync++;
      if (line_eop && !eop_q) n_eop++;
      sync_q <= line_sync;
      eop_q <= line_eop;
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] act, input logic [7:0] exp, input string what);
      n_tests++;
      if (act !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, act, exp);
      end
   endtask

   task automatic hang();
      err_total++;
      $display("[FAIL] %0t wait ran out", $time);
      finish_test();
   endtask

   // Code 3 sends low-speed data; the odd codes use full-speed edge rates
   function automatic logic [2:0] exp_speed(input logic [1:0] sel);
      return {((sel == 2'h3) ? 2'h2 : sel), sel[0]};
   endfunction

   // Handshake is judged just before the edge, as the design sees it
   task automatic run_pkt(input int n);
      int k;
      int s;
      int e;
      s = n_sync;
      e = n_eop;
      for (int i = 0; i < n; i++) begin
         usr_valid = 1'b1;
         usr_data = 8'($random(seed));
         usr_last = (i == n - 1);
         sent.push_back(usr_data);
         k = 0;
         do begin @(negedge clk); k++; end while (!usr_ready && k < 200);
         if (k >= 200) hang();
         @(posedge clk);
         #1;
      end
      usr_valid = 1'b0;
      usr_last = 1'b0;
      k = 0;
      while (n_eop == e && k < 200) begin @(posedge clk); k++; end
      if (k >= 200) hang();
      #1;
      check(8'(n_sync - s), 8'h01, "sync count");
      check(8'(n_eop - e), 8'h01, "eop count");
      check(8'(got.size()), 8'(sent.size()), "byte count");
      foreach (sent[i]) if (i < got.size()) check(got[i], sent[i], "byte");
      sent.delete();
      got.delete();
   endtask

   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      check({6'h00, fs_on, hs_on}, 8'h02, "reset terms");
      for (int s = 0; s < 4; s++) begin
         cfg_speed = 2'(s);
         repeat (4) @(posedge clk);
         #1;
         check({5'h00, line_speed, fs_edge}, {5'h00, exp_speed(2'(s))}, "speed");
      end
      for (int t = 0; t < 2; t++) begin
         cfg_term = 1'(t);
         repeat (4) @(posedge clk);
         #1;
         check({6'h00, fs_on, hs_on}, {6'h00, 1'(t), !1'(t)}, "terms");
      end
      cfg_speed = 2'h0;
      for (int p = 0; p < 5; p++) begin
         stall_en = p[0];
         run_pkt(p == 0 ? 1 : 2 + int'($random(seed) & 32'h7));
      end
      cfg_suspend = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check({5'h00, low_power, i_uphy_if.phy_clock_run, pu_line}, 8'h04, "suspend");
      cfg_suspend = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check({5'h00, low_power, i_uphy_if.phy_clock_run, pu_line}, 8'h03, "resume");
      // Device mode: no pull-up, pull-down follows termination select
      host_mode = 1'b0;
      for (int t = 0; t < 2; t++) begin
         cfg_term = 1'(t);
         repeat (4) @(posedge clk);
         #1;
         check({6'h00, pd_line, pu_line}, {6'h00, 1'(t), 1'b0}, "device pulls");
      end
      run_pkt(3);
      cfg_phy_reset = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check({6'h00, fs_on, i_uphy_if.tx_ready}, 8'h02, "phy reset");
      cfg_phy_reset = 1'b0;
      run_pkt(2);
      finish_test();
   end
endmodule
`default_nettype wire
